// ===== core/cisb_map.vh
// Constants for the increment / shift / branch execution slice.
// Assumes inclusion by bare name from the core and verif files.
`ifndef CISB_MAP_VH
`define CISB_MAP_VH

// ****************************************************************
// Operation select codes
// ****************************************************************
`define CISB_OP_W                  3
`define CISB_OP_INCREMENT_SKIP     3'h0
`define CISB_OP_JUMP               3'h1
`define CISB_OP_OR_LITERAL         3'h2
`define CISB_OP_INCREMENT          3'h3
`define CISB_OP_OR_REGISTER        3'h4
`define CISB_OP_LEFT_SHIFT         3'h5

// ****************************************************************
// Field widths and positions
// ****************************************************************
`define CISB_DATA_W                8
`define CISB_FILE_ADDR_W           7
`define CISB_LITERAL_W             11
`define CISB_PC_W                  15
`define CISB_PAGE_LATCH_W          7
`define CISB_JUMP_LIT_MSB          10
`define CISB_PAGE_SRC_MSB          6
`define CISB_PAGE_SRC_LSB          3
`define CISB_DEST_ACCUMULATOR      1'h0
`define CISB_DEST_FILE             1'h1

// ****************************************************************
// Reset values
// ****************************************************************
`define CISB_RESET_ACCUMULATOR     8'h00
`define CISB_RESET_ZERO            1'h0
`define CISB_RESET_CARRY           1'h0
`define CISB_RESET_PC              15'h0000

// ****************************************************************
// Timing counts in instruction cycles
// ****************************************************************
`define CISB_SINGLE_CYCLES         2'h1
`define CISB_DOUBLE_CYCLES         2'h2

`endif

// ===== core/cisb_alu.v
// Combinational data path of the execution slice.
// Assumes operands are stable within the issuing cycle.
`include "cisb_map.vh"
`default_nettype none

module cisb_alu (
  input  wire [`CISB_OP_W-1:0]       i_op,
  input  wire [`CISB_DATA_W-1:0]     i_accumulator,
  input  wire [`CISB_DATA_W-1:0]     i_file_data,
  input  wire [`CISB_DATA_W-1:0]     i_literal,
  output reg  [`CISB_DATA_W-1:0]     o_result,
  output wire                        o_result_zero,
  output reg                         o_carry_out
);

  // ****************************************************************
  // Zero detection shared by every flag-producing path
  // ****************************************************************
  function is_zero;
    input [`CISB_DATA_W-1:0] value;
    begin
      is_zero = (value == 8'h00);
    end
  endfunction

  assign o_result_zero = is_zero(o_result);

  // ****************************************************************
  // Result select
  // ****************************************************************
  always @* begin
    o_result    = 8'h00;
    o_carry_out = 1'h0;
    case (i_op)
      `CISB_OP_INCREMENT_SKIP: begin
        o_result = i_file_data + 8'h01;
      end
      `CISB_OP_INCREMENT: begin
        o_result = i_file_data + 8'h01;
      end
      `CISB_OP_OR_LITERAL: begin
        o_result = i_accumulator | i_literal;
      end
      `CISB_OP_OR_REGISTER: begin
        o_result = i_accumulator | i_file_data;
      end
      `CISB_OP_LEFT_SHIFT: begin
        o_carry_out = i_file_data[7];
        o_result    = {i_file_data[6:0], 1'h0};
      end
      default: begin
        o_result = 8'h00;
      end
    endcase
  end

endmodule
`default_nettype wire

// ===== core/cisb_exec.v
// Execution slice of the 8-bit core: increment, increment-skip, jump,
// inclusive OR with literal or file register, and logical left shift.
// Assumes decode presents one instruction per cycle with i_valid, and
// the register file returns the addressed byte in the same cycle.
`include "cisb_map.vh"
`default_nettype none

module cisb_exec (
  input  wire                            i_clk,
  input  wire                            i_reset_n,
  input  wire                            i_valid,
  input  wire [`CISB_OP_W-1:0]           i_op,
  input  wire [`CISB_FILE_ADDR_W-1:0]    i_file_addr,
  input  wire                            i_dest,
  input  wire [`CISB_LITERAL_W-1:0]      i_literal,
  input  wire [`CISB_DATA_W-1:0]         i_file_rdata,
  input  wire [`CISB_PAGE_LATCH_W-1:0]   i_page_latch,
  output reg                             o_ready_q,
  output reg  [`CISB_DATA_W-1:0]         o_accumulator_q,
  output reg                             o_zero_q,
  output reg                             o_carry_q,
  output reg                             o_file_we_q,
  output reg  [`CISB_FILE_ADDR_W-1:0]    o_file_waddr_q,
  output reg  [`CISB_DATA_W-1:0]         o_file_wdata_q,
  output reg                             o_pc_load_q,
  output reg  [`CISB_PC_W-1:0]           o_pc_target_q,
  output reg                             o_flush_q,
  output reg                             o_retire_q,
  output reg                             o_illegal_q
);

  // ****************************************************************
  // Sequencer states
  // ****************************************************************
  localparam [0:0] ST_RUN = 1'h0;
  localparam [0:0] ST_NOP = 1'h1;

  reg  [0:0]                   state_q;
  reg  [0:0]                   state_d;
  wire                         take;
  wire [`CISB_DATA_W-1:0]      alu_result;
  wire                         alu_zero;
  wire                         alu_carry;
  reg                          two_cycle;
  reg                          writes_file;
  reg                          writes_acc;
  reg                          sets_zero;
  reg                          sets_carry;
  reg                          legal;

  // Issue only while not burning the second cycle of a two-cycle op
  assign take = i_valid & o_ready_q;

  // ****************************************************************
  // Data path
  // ****************************************************************
  cisb_alu u_alu (
    .i_op          (i_op),
    .i_accumulator (o_accumulator_q),
    .i_file_data   (i_file_rdata),
    .i_literal     (i_literal[`CISB_DATA_W-1:0]),
    .o_result      (alu_result),
    .o_result_zero (alu_zero),
    .o_carry_out   (alu_carry)
  );

  // ****************************************************************
  // Per-operation decode
  // ****************************************************************
  always @* begin
    two_cycle   = 1'h0;
    writes_file = 1'h0;
    writes_acc  = 1'h0;
    sets_zero   = 1'h0;
    sets_carry  = 1'h0;
    legal       = 1'h1;
    case (i_op)
      `CISB_OP_INCREMENT_SKIP: begin
        two_cycle   = alu_zero;
        writes_file = (i_dest == `CISB_DEST_FILE);
        writes_acc  = (i_dest == `CISB_DEST_ACCUMULATOR);
      end
      `CISB_OP_JUMP: begin
        two_cycle = 1'h1;
      end
      `CISB_OP_OR_LITERAL: begin
        writes_acc = 1'h1;
        sets_zero  = 1'h1;
      end
      `CISB_OP_INCREMENT,
      `CISB_OP_OR_REGISTER: begin
        writes_file = (i_dest == `CISB_DEST_FILE);
        writes_acc  = (i_dest == `CISB_DEST_ACCUMULATOR);
        sets_zero   = 1'h1;
      end
      `CISB_OP_LEFT_SHIFT: begin
        writes_file = (i_dest == `CISB_DEST_FILE);
        writes_acc  = (i_dest == `CISB_DEST_ACCUMULATOR);
        sets_zero   = 1'h1;
        sets_carry  = 1'h1;
      end
      default: begin
        legal = 1'h0;
      end
    endcase
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_RUN: begin
        if (take && legal && two_cycle) begin
          state_d = ST_NOP;
        end
      end
      ST_NOP: begin
        state_d = ST_RUN;
      end
      default: begin
        state_d = ST_RUN;
      end
    endcase
  end

  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      state_q   <= ST_RUN;
      o_ready_q <= 1'h0;
    end else begin
      state_q   <= state_d;
      // Ready drops for exactly the one no-operation cycle
      o_ready_q <= (state_d == ST_RUN);
    end
  end

  // ****************************************************************
  // Architectural state and write-back
  // ****************************************************************
  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_accumulator_q <= `CISB_RESET_ACCUMULATOR;
      o_zero_q        <= `CISB_RESET_ZERO;
      o_carry_q       <= `CISB_RESET_CARRY;
      o_file_we_q     <= 1'h0;
      o_file_waddr_q  <= 7'h00;
      o_file_wdata_q  <= 8'h00;
      o_pc_load_q     <= 1'h0;
      o_pc_target_q   <= `CISB_RESET_PC;
      o_flush_q       <= 1'h0;
      o_retire_q      <= 1'h0;
      o_illegal_q     <= 1'h0;
    end else begin
      o_file_we_q <= take & legal & writes_file;
      o_pc_load_q <= take & (i_op == `CISB_OP_JUMP);
      // Fetch holds the prefetched word; flush turns it into a no-operation
      o_flush_q   <= take & legal & two_cycle;
      o_retire_q  <= take & legal;
      o_illegal_q <= take & ~legal;
      if (take && legal) begin
        o_file_waddr_q <= i_file_addr;
        o_file_wdata_q <= alu_result;
        if (writes_acc) begin
          o_accumulator_q <= alu_result;
        end
        if (sets_zero) begin
          o_zero_q <= alu_zero;
        end
        if (sets_carry) begin
          o_carry_q <= alu_carry;
        end
        if (i_op == `CISB_OP_JUMP) begin
          o_pc_target_q <= {i_page_latch[`CISB_PAGE_SRC_MSB:`CISB_PAGE_SRC_LSB],
                            i_literal[`CISB_JUMP_LIT_MSB:0]};
        end
      end
    end
  end

endmodule
`default_nettype wire

// ===== verif/cisb_exec_chk.sv
// Checker for the execution slice, bound onto cisb_exec.
// Assumes the top module's ports only, one clock, synchronous reset.
`include "cisb_map.vh"
`default_nettype none
module cisb_exec_chk (
  input wire logic                          i_clk,
  input wire logic                          i_reset_n,
  input wire logic                          i_valid,
  input wire logic [`CISB_OP_W-1:0]         i_op,
  input wire logic [`CISB_FILE_ADDR_W-1:0]  i_file_addr,
  input wire logic                          i_dest,
  input wire logic [`CISB_LITERAL_W-1:0]    i_literal,
  input wire logic [`CISB_DATA_W-1:0]       i_file_rdata,
  input wire logic [`CISB_PAGE_LATCH_W-1:0] i_page_latch,
  input wire logic                          o_ready_q,
  input wire logic [`CISB_DATA_W-1:0]       o_accumulator_q,
  input wire logic                          o_zero_q,
  input wire logic                          o_carry_q,
  input wire logic                          o_file_we_q,
  input wire logic [`CISB_FILE_ADDR_W-1:0]  o_file_waddr_q,
  input wire logic [`CISB_DATA_W-1:0]       o_file_wdata_q,
  input wire logic                          o_pc_load_q,
  input wire logic [`CISB_PC_W-1:0]         o_pc_target_q,
  input wire logic                          o_flush_q,
  input wire logic                          o_retire_q,
  input wire logic                          o_illegal_q
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  // Taken only while ready, so $past never reaches into reset
  wire tk = i_valid && o_ready_q;
  a_jump_low: assert property (tk && i_op == `CISB_OP_JUMP |=>
    o_pc_load_q && o_pc_target_q[10:0] == $past(i_literal)) else $error("jump low bits wrong");
  a_jump_page: assert property (tk && i_op == `CISB_OP_JUMP |=>
    o_pc_target_q[14:11] == $past(i_page_latch[6:3])) else $error("jump page bits wrong");
  a_jump_stall: assert property (tk && i_op == `CISB_OP_JUMP |=>
    !o_ready_q && o_flush_q && $stable(o_zero_q) && $stable(o_carry_q) ##1 o_ready_q) else $error("jump timing");
  a_skip_flags: assert property (tk && i_op == `CISB_OP_INCREMENT_SKIP && i_dest |=>
    o_file_we_q && o_file_wdata_q == $past(i_file_rdata) + 8'h01 && $stable(o_zero_q) && $stable(o_carry_q))
    else $error("skip increment wrong");
  a_skip_zero: assert property (tk && i_op == `CISB_OP_INCREMENT_SKIP && i_file_rdata == 8'hff |=>
    o_flush_q && !o_ready_q) else $error("zero skip missing");
  a_one_cycle: assert property (tk && (i_op inside {[3'h2:3'h5]} || i_op == 3'h0 && i_file_rdata != 8'hff) |=>
    o_ready_q && !o_flush_q) else $error("single cycle op stalled");
  a_or_literal: assert property (tk && i_op == `CISB_OP_OR_LITERAL |=>
    o_accumulator_q == ($past(o_accumulator_q) | $past(i_literal[7:0])) && o_zero_q == (o_accumulator_q == 8'h00))
    else $error("or literal wrong");
  a_shift_flags: assert property (tk && i_op == `CISB_OP_LEFT_SHIFT |=>
    o_carry_q == $past(i_file_rdata[7]) && o_zero_q == ($past(i_file_rdata[6:0]) == 7'h00))
    else $error("shift flags wrong");
  a_inc_file: assert property (tk && i_op == `CISB_OP_INCREMENT && i_dest |=>
    o_file_we_q && o_file_waddr_q == $past(i_file_addr) && o_file_wdata_q == $past(i_file_rdata) + 8'h01)
    else $error("increment write back wrong");
  a_or_register: assert property (tk && i_op == `CISB_OP_OR_REGISTER && !i_dest |=>
    o_accumulator_q == ($past(o_accumulator_q) | $past(i_file_rdata)) && !o_file_we_q && o_retire_q)
    else $error("or register wrong");
  a_illegal_quiet: assert property (tk && i_op > 3'h5 |=>
    o_illegal_q && !o_retire_q && !o_file_we_q && $stable(o_accumulator_q)) else $error("illegal op changed state");
endmodule
bind cisb_exec cisb_exec_chk chk_u (.i_clk, .i_reset_n, .i_valid, .i_op, .i_file_addr, .i_dest, .i_literal,
  .i_file_rdata, .i_page_latch, .o_ready_q, .o_accumulator_q, .o_zero_q, .o_carry_q, .o_file_we_q,
  .o_file_waddr_q, .o_file_wdata_q, .o_pc_load_q, .o_pc_target_q, .o_flush_q, .o_retire_q, .o_illegal_q);
`default_nettype wire

// ===== verif/cisb_exec_tb_top.sv
// Self-checking bench for the execution slice.
// Assumes the bench plays decode and register file itself.
`include "cisb_map.vh"
`default_nettype none
module cisb_exec_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************************************
  // Stimulus and checks
  // ****************************************************************
  logic        i_clk = 1'b0;
  logic        i_reset_n = 1'b0;
  logic        i_valid = 1'b0;
  logic        i_dest = 1'b0;
  logic [2:0]  i_op = 3'h0;
  logic [6:0]  i_file_addr = 7'h00;
  logic [10:0] i_literal = 11'h000;
  logic [7:0]  i_file_rdata = 8'h00;
  logic [6:0]  i_page_latch = 7'h00;
  wire         o_ready_q, o_zero_q, o_carry_q, o_file_we_q, o_pc_load_q, o_flush_q, o_retire_q, o_illegal_q;
  wire  [7:0]  o_accumulator_q, o_file_wdata_q;
  wire  [6:0]  o_file_waddr_q;
  wire  [14:0] o_pc_target_q;
  int          n_errors = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  bit          hold = 1'b0;
  logic [7:0]  w = 8'h00;
  logic [7:0]  k [3] = '{8'h00, 8'h5a, 8'h81};
  cisb_exec dut_u (.i_clk, .i_reset_n, .i_valid, .i_op, .i_file_addr, .i_dest, .i_literal, .i_file_rdata,
    .i_page_latch, .o_ready_q, .o_accumulator_q, .o_zero_q, .o_carry_q, .o_file_we_q, .o_file_waddr_q,
    .o_file_wdata_q, .o_pc_load_q, .o_pc_target_q, .o_flush_q, .o_retire_q, .o_illegal_q);
  always #5 i_clk = ~i_clk;
  task automatic test_done;
    $display("checked %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 1000) begin
      n_errors++;
      test_done;
    end
  end
  // Wide enough for the longest bundle of outputs compared in one call
  task automatic chk(input string n, input logic [23:0] g, input logic [23:0] e);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  // Holds one instruction for one taking edge, leaving i_valid high on return while hold is set; outputs are settled on return
  task automatic exe(input logic [2:0] op, input logic [6:0] a, input logic d, input logic [10:0] l,
                     input logic [7:0] f, input logic [6:0] p);
    @(posedge i_clk);
    #1;
    {i_valid, i_op, i_file_addr, i_dest, i_literal, i_file_rdata, i_page_latch} = {1'b1, op, a, d, l, f, p};
    @(posedge i_clk);
    #1;
    if (!hold) i_valid = 1'b0;
  endtask
  task automatic t_basic;
    for (int i = 0; i < 3; i++) begin
      w = w | k[i];
      exe(3'h2, 7'h00, 1'b0, {3'h7, k[i]}, 8'h00, 7'h00);
      chk("or acc", o_accumulator_q, w);
      chk("or zero", o_zero_q, w == 8'h00);
    end
    exe(3'h3, 7'h7f, 1'b0, 11'h000, 8'h7f, 7'h00);
    chk("inc acc", {o_accumulator_q, o_zero_q, o_file_we_q}, {8'h80, 2'b00});
    exe(3'h3, 7'h7f, 1'b1, 11'h000, 8'hff, 7'h00);
    chk("inc file", {o_file_we_q, o_file_waddr_q, o_file_wdata_q, o_zero_q}, {1'b1, 7'h7f, 8'h00, 1'b1});
    chk("inc time", {o_ready_q, o_flush_q, o_accumulator_q}, {2'b10, 8'h80});
    $display("basic done");
  endtask
  task automatic t_skip;
    hold = 1'b1;
    exe(3'h0, 7'h12, 1'b1, 11'h000, 8'hff, 7'h00);
    chk("skip file", {o_file_we_q, o_file_waddr_q, o_file_wdata_q}, {8'h92, 8'h00});
    chk("skip flow", {o_flush_q, o_ready_q, o_zero_q}, 3'b101);
    hold = 1'b0;
    @(posedge i_clk);
    #1;
    i_valid = 1'b0;
    chk("no op slot", {o_file_we_q, o_flush_q, o_retire_q, o_ready_q}, 4'h1);
    exe(3'h0, 7'h01, 1'b0, 11'h000, 8'h41, 7'h00);
    chk("skip acc", {o_accumulator_q, o_flush_q, o_ready_q, o_zero_q}, {8'h42, 3'b011});
    exe(3'h4, 7'h33, 1'b1, 11'h000, 8'h0c, 7'h00);
    chk("orf file", {o_file_we_q, o_file_waddr_q, o_file_wdata_q}, {8'hb3, 8'h4e});
    exe(3'h4, 7'h33, 1'b0, 11'h000, 8'h81, 7'h00);
    chk("orf acc", {o_accumulator_q, o_zero_q, o_file_we_q}, {8'hc3, 2'b00});
    $display("skip done");
  endtask
  task automatic t_shift_jump;
    exe(3'h5, 7'h05, 1'b1, 11'h000, 8'h41, 7'h00);
    chk("shl file", {o_file_wdata_q, o_carry_q, o_zero_q, o_accumulator_q}, {8'h82, 2'b00, 8'hc3});
    exe(3'h5, 7'h05, 1'b0, 11'h000, 8'h80, 7'h00);
    chk("shl acc", {o_accumulator_q, o_carry_q, o_zero_q}, {8'h00, 2'b11});
    exe(3'h1, 7'h00, 1'b0, 11'h7ff, 8'h00, 7'h55);
    chk("jump pc", {o_pc_load_q, o_pc_target_q}, {1'b1, 15'h57ff});
    chk("jump flow", {o_flush_q, o_ready_q, o_zero_q, o_carry_q}, 4'hb);
    exe(3'h1, 7'h00, 1'b0, 11'h000, 8'h00, 7'h78);
    chk("jump page", o_pc_target_q, 15'h7800);
    exe(3'h6, 7'h00, 1'b0, 11'h0ff, 8'h00, 7'h00);
    chk("illegal", {o_illegal_q, o_retire_q, o_file_we_q, o_accumulator_q}, 11'h400);
    $display("shift jump done");
  endtask
  initial begin
    repeat (12) @(posedge i_clk);
    #1;
    i_reset_n = 1'b1;
    t_basic;
    t_skip;
    t_shift_jump;
    test_done;
  end
endmodule
`default_nettype wire
